/* rtl/fifo_alloc_pkg.sv */
package fifo_alloc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] RX_DATA_PORT = 8'h00;
  localparam logic [7:0] TX_DATA_PORT = 8'h20;
  localparam logic [7:0] TX_DATA_LAST = 8'h24;
  localparam logic [7:0] ALLOC_DATA = 8'h60;
  localparam logic [7:0] ALLOC_STATUS = 8'h64;
  localparam logic [7:0] DROP_COUNT = 8'h68;
  localparam logic [7:0] ERROR_STATUS = 8'h6C;
  localparam logic [7:0] RX_USED = 8'h70;
  localparam logic [7:0] HW_CONFIG = 8'h74;
  localparam logic [7:0] RX_DP_CONTROL = 8'h78;
  localparam int SOFTWARE_RESET_TRIGGER_BIT = 0;
  localparam int TIMEOUT_BIT = 1;
  localparam int SEL_LSB = 16;
  localparam int SEL_W = 4;
  localparam int FFWD_BIT = 31;
  localparam int TXE_BIT = 0;
  localparam int RXE_BIT = 1;
  localparam logic [3:0] SEL_MIN = 4'h2;
  localparam logic [3:0] SEL_MAX = 4'hE;
  localparam logic [3:0] SEL_RESET = 4'h5;
  localparam int KB_SHIFT = 10;
  localparam int DW_SHIFT = 2;
  localparam int RX_STATUS_SHIFT = 4;
  localparam logic [15:0] TOTAL_BYTES = 16'h4000;
  localparam logic [15:0] TX_STATUS_BYTES = 16'h0200;
  localparam int TX_STATUS_WORDS = 128;
  localparam logic [15:0] RX_FULL_MARGIN_DW = 16'h0004;
  localparam int TX_MIL_BYTES = 2048;
  localparam int RX_MIL_BYTES = 128;
  localparam logic [1:0] MIL_TX_FRAMES = 2'h2;
  localparam int TX_DATA_MAX_DW = 3456;
  localparam int RX_DATA_MAX_DW = 3360;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFTWARE_RESET_TRIGGER_TIMEOUT_NS = 10000;
  localparam int SOFTWARE_RESET_TRIGGER_TIMEOUT_CYCLES = SOFTWARE_RESET_TRIGGER_TIMEOUT_NS / CLK_PERIOD_NS;
endpackage

/* rtl/fifo_alloc_if.sv */
`timescale 1ns/100ps
interface fifo_alloc_if;
  logic [7:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport dev (input addr, input rd, input wr, input wdata, output rdata);
  modport host (output addr, output rd, output wr, output wdata,
                input rdata);
endinterface

/* rtl/mil_fifo.sv */
`timescale 1ns/100ps
module mil_fifo #(
  parameter int W = 33,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_out = cnt_r != FULL_CNT;
  assign out_valid_out = cnt_r != '0;
  assign out_data_out = mem[rp_r];

  always_comb begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    wp_nxt = push ? ((wp_r == LAST_PTR) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == LAST_PTR) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    if (flush_in) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wp_r] <= in_data_in;
    end
  end
endmodule

/* rtl/fifo_alloc_device.sv */
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
module fifo_alloc_device #(
  parameter int SOFTWARE_RESET_TRIGGER_TIMEOUT_CYCLES = fifo_alloc_pkg::SOFTWARE_RESET_TRIGGER_TIMEOUT_CYCLES,
  parameter logic [3:0] SEL_RESET = fifo_alloc_pkg::SEL_RESET
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  fifo_alloc_if.dev link,
  input wire logic phy_clocks_running_in,
  input wire logic tx_error_in,
  input wire logic rx_error_in,
  output logic [31:0] tx_word_out,
  output logic tx_last_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic rx_valid_in,
  input wire logic [31:0] rx_word_in,
  input wire logic rx_last_in
);
  localparam int TXD = fifo_alloc_pkg::TX_DATA_MAX_DW;
  localparam int RXD = fifo_alloc_pkg::RX_DATA_MAX_DW;
  localparam logic [11:0] TX_LAST = 12'(TXD - 1);
  localparam logic [11:0] RX_LAST = 12'(RXD - 1);
  localparam logic [15:0] TO_LAST = 16'(SOFTWARE_RESET_TRIGGER_TIMEOUT_CYCLES - 1);
  typedef enum logic [1:0] {SR_IDLE = 2'b01, SR_PEND = 2'b10} software_reset_trigger_e;

  logic [32:0] tx_mem [TXD];
  logic [32:0] rx_mem [RXD];
  software_reset_trigger_e sr_r, sr_nxt;
  logic [15:0] to_cnt_r, to_cnt_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic timeout_r, timeout_nxt, seen_r, seen_nxt, ffwd_r, ffwd_nxt;
  logic txe_r, txe_nxt, rxe_r, rxe_nxt, drop_r, drop_nxt;
  logic [31:0] drop_cnt_r, drop_cnt_nxt, rdata_r, rdata_nxt;
  logic [11:0] txw_r, txw_nxt, txr_r, txr_nxt, rxw_r, rxw_nxt;
  logic [11:0] rxr_r, rxr_nxt;
  logic [15:0] txl_r, txl_nxt, rxl_r, rxl_nxt;
  logic [1:0] frames_r, frames_nxt;
  logic phy_s1_r, phy_s2_r;
  logic reg_wr, software_reset_trigger_now, tx_push, tx_move, rx_move, host_pop, ff_pop;
  logic mtx_ready, mrx_valid, mrx_push, mrx_ready;
  logic [32:0] mrx_data, tx_head, rx_head;
  logic [15:0] tx_total, tx_data_b, rx_total, rx_stat_b, rx_data_b;

  mil_fifo #(
    .W(33),
    .DEPTH(fifo_alloc_pkg::TX_MIL_BYTES >> fifo_alloc_pkg::DW_SHIFT)
  ) u_tx_mil (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .flush_in(software_reset_trigger_now),
    .in_valid_in(tx_move),
    .in_ready_out(mtx_ready),
    .in_data_in(tx_head),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in),
    .out_data_out({tx_last_out, tx_word_out})
  );

  mil_fifo #(
    .W(33),
    .DEPTH(fifo_alloc_pkg::RX_MIL_BYTES >> fifo_alloc_pkg::DW_SHIFT)
  ) u_rx_mil (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .flush_in(software_reset_trigger_now),
    .in_valid_in(mrx_push),
    .in_ready_out(mrx_ready),
    .in_data_in({rx_last_in, rx_word_in}),
    .out_valid_out(mrx_valid),
    .out_ready_in(rx_move),
    .out_data_out(mrx_data)
  );

  always_comb begin
    tx_total = 16'(sel_r) << fifo_alloc_pkg::KB_SHIFT;
    tx_data_b = tx_total - fifo_alloc_pkg::TX_STATUS_BYTES;
    rx_total = fifo_alloc_pkg::TOTAL_BYTES - tx_total;
    rx_stat_b = rx_total >> fifo_alloc_pkg::RX_STATUS_SHIFT;
    rx_data_b = rx_total - rx_stat_b;
  end

  assign tx_head = tx_mem[txr_r];
  assign rx_head = rx_mem[rxr_r];
  assign link.rdata = rdata_r;

  always_comb begin
    sr_nxt = sr_r;
    to_cnt_nxt = to_cnt_r;
    sel_nxt = sel_r;
    timeout_nxt = timeout_r;
    seen_nxt = seen_r || link.rd;
    ffwd_nxt = ffwd_r;
    txe_nxt = txe_r;
    rxe_nxt = rxe_r;
    drop_nxt = drop_r;
    drop_cnt_nxt = drop_cnt_r;
    software_reset_trigger_now = 1'b0;
    tx_push = 1'b0;
    host_pop = 1'b0;
    reg_wr = link.wr && seen_r;
    if (reg_wr) begin
      case (link.addr)
        fifo_alloc_pkg::HW_CONFIG: begin
          sel_nxt = link.wdata[fifo_alloc_pkg::SEL_LSB +:
                               fifo_alloc_pkg::SEL_W];
          if (link.wdata[fifo_alloc_pkg::SOFTWARE_RESET_TRIGGER_BIT]) begin
            sr_nxt = SR_PEND;
            to_cnt_nxt = '0;
          end
        end
        fifo_alloc_pkg::RX_DP_CONTROL: begin
          if (link.wdata[fifo_alloc_pkg::FFWD_BIT]) begin
            ffwd_nxt = 1'b1;
          end
        end
        fifo_alloc_pkg::TX_DATA_PORT, fifo_alloc_pkg::TX_DATA_LAST: begin
          // overflow is flagged rather than silently lost
          if (txl_r >= (tx_data_b >> fifo_alloc_pkg::DW_SHIFT)) begin
            txe_nxt = 1'b1;
          end else begin
            tx_push = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (link.rd && link.addr == fifo_alloc_pkg::RX_DATA_PORT && !ffwd_r) begin
      if (rxl_r == '0) begin
        rxe_nxt = 1'b1;
      end else begin
        host_pop = 1'b1;
      end
    end
    case (sr_r)
      SR_IDLE: begin
      end
      SR_PEND: begin
        if (phy_s2_r) begin
          software_reset_trigger_now = 1'b1;
          sr_nxt = SR_IDLE;
          timeout_nxt = 1'b0;
        end else if (to_cnt_r == TO_LAST) begin
          timeout_nxt = 1'b1;
          sr_nxt = SR_IDLE;
        end else begin
          to_cnt_nxt = to_cnt_r + 16'h0001;
        end
      end
      default: sr_nxt = SR_IDLE;
    endcase
    tx_move = (txl_r != '0) && mtx_ready &&
              (frames_r != fifo_alloc_pkg::MIL_TX_FRAMES);
    rx_move = mrx_valid && (rxl_r < ((rx_data_b >> fifo_alloc_pkg::DW_SHIFT)
              - fifo_alloc_pkg::RX_FULL_MARGIN_DW));
    ff_pop = ffwd_r && (rxl_r != '0);
    if (ff_pop && rx_head[32]) begin
      ffwd_nxt = 1'b0;
    end
    mrx_push = rx_valid_in && !drop_r;
    if (rx_valid_in && (drop_r || !mrx_ready)) begin
      if (!drop_r) begin
        drop_cnt_nxt = drop_cnt_r + 32'h0000_0001;
      end
      drop_nxt = !rx_last_in;
    end
    frames_nxt = frames_r + 2'(tx_move && tx_head[32])
                 - 2'(tx_valid_out && tx_ready_in && tx_last_out);
    txw_nxt = tx_push ? ((txw_r == TX_LAST) ? '0 : txw_r + 12'h001) : txw_r;
    txr_nxt = tx_move ? ((txr_r == TX_LAST) ? '0 : txr_r + 12'h001) : txr_r;
    rxw_nxt = rx_move ? ((rxw_r == RX_LAST) ? '0 : rxw_r + 12'h001) : rxw_r;
    rxr_nxt = (ff_pop || host_pop) ?
              ((rxr_r == RX_LAST) ? '0 : rxr_r + 12'h001) : rxr_r;
    txl_nxt = txl_r + 16'(tx_push) - 16'(tx_move);
    rxl_nxt = rxl_r + 16'(rx_move) - 16'(ff_pop || host_pop);
    if (software_reset_trigger_now) begin
      // allocation select survives soft reset; fifos restart empty
      txw_nxt = '0;
      txr_nxt = '0;
      rxw_nxt = '0;
      rxr_nxt = '0;
      txl_nxt = '0;
      rxl_nxt = '0;
      frames_nxt = '0;
      drop_cnt_nxt = '0;
      drop_nxt = 1'b0;
      ffwd_nxt = 1'b0;
      seen_nxt = link.rd;
      txe_nxt = tx_error_in;
      rxe_nxt = rx_error_in;
    end else begin
      txe_nxt = txe_nxt || tx_error_in;
      rxe_nxt = rxe_nxt || rx_error_in;
    end
    rdata_nxt = '0;
    if (link.rd) begin
      case (link.addr)
        fifo_alloc_pkg::RX_DATA_PORT:
          rdata_nxt = host_pop ? rx_head[31:0] : '0;
        fifo_alloc_pkg::ALLOC_DATA: rdata_nxt = {rx_data_b, tx_data_b};
        fifo_alloc_pkg::ALLOC_STATUS:
          rdata_nxt = {fifo_alloc_pkg::TX_STATUS_BYTES, rx_stat_b};
        fifo_alloc_pkg::DROP_COUNT: rdata_nxt = drop_cnt_r;
        fifo_alloc_pkg::ERROR_STATUS: rdata_nxt = {30'h0, rxe_r, txe_r};
        fifo_alloc_pkg::RX_USED:
          rdata_nxt = {16'h0, rxl_r << fifo_alloc_pkg::DW_SHIFT};
        fifo_alloc_pkg::HW_CONFIG:
          rdata_nxt = {12'h0, sel_r, 14'h0, timeout_r, sr_r == SR_PEND};
        fifo_alloc_pkg::RX_DP_CONTROL: rdata_nxt = {ffwd_r, 31'h0};
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sr_r <= SR_IDLE;
      sel_r <= SEL_RESET;
      {to_cnt_r, txl_r, rxl_r} <= '0;
      {drop_cnt_r, rdata_r} <= '0;
      {txw_r, txr_r, rxw_r, rxr_r, frames_r} <= '0;
      {timeout_r, seen_r, ffwd_r, txe_r, rxe_r, drop_r} <= '0;
      {phy_s1_r, phy_s2_r} <= 2'b00;
    end else begin
      sr_r <= sr_nxt;
      sel_r <= sel_nxt;
      {to_cnt_r, txl_r, rxl_r} <= {to_cnt_nxt, txl_nxt, rxl_nxt};
      {drop_cnt_r, rdata_r} <= {drop_cnt_nxt, rdata_nxt};
      {txw_r, txr_r, rxw_r, rxr_r} <= {txw_nxt, txr_nxt, rxw_nxt, rxr_nxt};
      frames_r <= frames_nxt;
      {timeout_r, seen_r, ffwd_r} <= {timeout_nxt, seen_nxt, ffwd_nxt};
      {txe_r, rxe_r, drop_r} <= {txe_nxt, rxe_nxt, drop_nxt};
      phy_s1_r <= phy_clocks_running_in;
      phy_s2_r <= phy_s1_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (tx_push) begin
      tx_mem[txw_r] <= {link.addr == fifo_alloc_pkg::TX_DATA_LAST, link.wdata};
    end
    if (rx_move) begin
      rx_mem[rxw_r] <= mrx_data;
    end
  end
endmodule

/* rtl/fifo_alloc_host.sv */
`timescale 1ns/100ps
module fifo_alloc_host (
  input wire logic core_clk_in,
  input wire logic rst_in,
  fifo_alloc_if.host link,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out
);
  typedef enum logic [8:0] {
    H_IDLE = 9'b000000001, H_WDATA = 9'b000000010, H_PRE = 9'b000000100,
    H_PRIME = 9'b000001000, H_PRIME_W = 9'b000010000,
    H_POLL = 9'b000100000, H_POLL_W = 9'b001000000,
    H_OP = 9'b010000000, H_OP_W = 9'b100000000
  } hstate_e;
  hstate_e st_r, st_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic wr_r, wr_nxt, primed_r, primed_nxt, busy_r, busy_nxt;
  logic [31:0] wdata_r, wdata_nxt, hrdata_r, hrdata_nxt;
  logic [3:0] sel_w;

  assign hreadyout_out = st_r == H_IDLE;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_r;
  assign link.wdata = wdata_r;
  assign link.rd = (st_r == H_PRIME) || (st_r == H_POLL) ||
                   (st_r == H_OP && !wr_r);
  assign link.wr = st_r == H_OP && wr_r;
  assign link.addr = (st_r == H_POLL) ? fifo_alloc_pkg::RX_DP_CONTROL :
                     (st_r == H_PRIME) ? fifo_alloc_pkg::HW_CONFIG : addr_r;
  assign sel_w = wdata_r[fifo_alloc_pkg::SEL_LSB +: fifo_alloc_pkg::SEL_W];

  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    wr_nxt = wr_r;
    primed_nxt = primed_r;
    busy_nxt = busy_r;
    wdata_nxt = wdata_r;
    hrdata_nxt = hrdata_r;
    case (st_r)
      H_IDLE: begin
        // hsize ignored: only whole-word single transfers are served
        if (hsel_in && htrans_in[1] && hready_in) begin
          addr_nxt = haddr_in[7:0];
          wr_nxt = hwrite_in;
          st_nxt = hwrite_in ? H_WDATA : H_PRE;
        end
      end
      H_WDATA: begin
        wdata_nxt = hwdata_in;
        st_nxt = H_PRE;
      end
      H_PRE: begin
        if (wr_r && !primed_r) begin
          st_nxt = H_PRIME;
        end else if (!wr_r && busy_r &&
                     addr_r == fifo_alloc_pkg::RX_DATA_PORT) begin
          st_nxt = H_POLL;
        end else if (wr_r && addr_r == fifo_alloc_pkg::HW_CONFIG &&
                     (sel_w < fifo_alloc_pkg::SEL_MIN ||
                      sel_w > fifo_alloc_pkg::SEL_MAX)) begin
          st_nxt = H_IDLE;
        end else begin
          st_nxt = H_OP;
        end
      end
      H_PRIME: st_nxt = H_PRIME_W;
      H_PRIME_W: begin
        primed_nxt = 1'b1;
        st_nxt = H_PRE;
      end
      H_POLL: st_nxt = H_POLL_W;
      H_POLL_W: begin
        busy_nxt = link.rdata[fifo_alloc_pkg::FFWD_BIT];
        st_nxt = H_PRE;
      end
      H_OP: begin
        st_nxt = H_OP_W;
        if (wr_r && addr_r == fifo_alloc_pkg::HW_CONFIG &&
            wdata_r[fifo_alloc_pkg::SOFTWARE_RESET_TRIGGER_BIT]) begin
          primed_nxt = 1'b0;
        end
        if (wr_r && addr_r == fifo_alloc_pkg::RX_DP_CONTROL &&
            wdata_r[fifo_alloc_pkg::FFWD_BIT]) begin
          busy_nxt = 1'b1;
        end
      end
      H_OP_W: begin
        hrdata_nxt = wr_r ? hrdata_r : link.rdata;
        st_nxt = H_IDLE;
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= H_IDLE;
      addr_r <= '0;
      wr_r <= 1'b0;
      primed_r <= 1'b0;
      busy_r <= 1'b0;
      wdata_r <= '0;
      hrdata_r <= '0;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      wr_r <= wr_nxt;
      primed_r <= primed_nxt;
      busy_r <= busy_nxt;
      wdata_r <= wdata_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end
endmodule

/* test/fifo_alloc_monitor.sv */
`timescale 1ns/100ps
module fifo_alloc_monitor (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [31:0] rdata_in
);
  logic seen_r, seen_nxt, busy_r, busy_nxt, chk_r, chk_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic [15:0] tx_b, rx_b, rxs_b;

  // shadow of the select, tracked from link writes only
  always_comb begin
    seen_nxt = seen_r | rd_in;
    sel_nxt = sel_r;
    busy_nxt = busy_r;
    chk_nxt = rd_in && addr_in == fifo_alloc_pkg::RX_DP_CONTROL;
    if (chk_r && !rdata_in[31]) busy_nxt = 1'b0;
    if (wr_in && addr_in == fifo_alloc_pkg::RX_DP_CONTROL && wdata_in[31])
      busy_nxt = 1'b1;
    if (wr_in && addr_in == fifo_alloc_pkg::HW_CONFIG) begin
      if (wdata_in[0]) seen_nxt = 1'b0;
      if (wdata_in[19:16] >= 4'h2 && wdata_in[19:16] <= 4'hE)
        sel_nxt = wdata_in[19:16];
    end
    tx_b = {2'h0, sel_r, 10'h000};
    rx_b = 16'h4000 - tx_b;
    rxs_b = rx_b >> 4;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_r <= 1'b0;
      busy_r <= 1'b0;
      chk_r <= 1'b0;
      sel_r <= fifo_alloc_pkg::SEL_RESET;
    end else begin
      seen_r <= seen_nxt;
      busy_r <= busy_nxt;
      chk_r <= chk_nxt;
      sel_r <= sel_nxt;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  write_gate_a: assert property (wr_in |-> seen_r)
    else $error("write reached device before any read");
  alloc_data_a: assert property (
    rd_in && addr_in == fifo_alloc_pkg::ALLOC_DATA
    |=> rdata_in == {rx_b - rxs_b, tx_b - 16'h0200})
    else $error("data fifo sizes wrong");
  alloc_status_a: assert property (
    rd_in && addr_in == fifo_alloc_pkg::ALLOC_STATUS
    |=> rdata_in == {16'h0200, rxs_b})
    else $error("status fifo sizes wrong");
  cfg_select_a: assert property (
    rd_in && addr_in == fifo_alloc_pkg::HW_CONFIG
    |=> rdata_in[19:16] == sel_r)
    else $error("allocation select wrong");
  skip_quiet_a: assert property (
    rd_in && addr_in == fifo_alloc_pkg::RX_DATA_PORT |-> !busy_r)
    else $error("rx data read while skipping");
  unmapped_zero_a: assert property (
    rd_in && addr_in == 8'h7C |=> rdata_in == 32'h0)
    else $error("unmapped read not zero");
  link_pulse_a: assert property ((rd_in || wr_in) |=> !(rd_in || wr_in))
    else $error("link strobe longer than one cycle");
  link_excl_a: assert property (!(rd_in && wr_in))
    else $error("read and write together");

  cover property (wr_in && addr_in == fifo_alloc_pkg::HW_CONFIG &&
                  wdata_in[0]);
  cover property (wr_in && addr_in == fifo_alloc_pkg::RX_DP_CONTROL &&
                  wdata_in[31]);
  cover property (chk_r && rdata_in[31]);
endmodule

/* test/fifo_allocation_rx_discard_test.sv */
`timescale 1ns/100ps
module fifo_allocation_rx_discard_test;
  logic clk, rst, hsel, hwrite, hrdy, hresp, phy, transmit_error_flag, receive_error_flag;
  logic txr, txv, txl, rxv, rxl;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, txw, rxw;
  logic [3:0] cur_sel;
  int n_mismatch, n_compared;

  fifo_alloc_if fifo_alloc_if_i ();
  fifo_alloc_host fifo_alloc_host_i (.core_clk_in(clk), .rst_in(rst),
    .link(fifo_alloc_if_i), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp));
  // short timeout keeps the stalled-reset case quick
  fifo_alloc_device #(.SOFTWARE_RESET_TRIGGER_TIMEOUT_CYCLES(20)) fifo_alloc_device_i (
    .core_clk_in(clk), .rst_in(rst), .link(fifo_alloc_if_i),
    .phy_clocks_running_in(phy), .tx_error_in(transmit_error_flag), .rx_error_in(receive_error_flag),
    .tx_word_out(txw), .tx_last_out(txl), .tx_valid_out(txv),
    .tx_ready_in(txr), .rx_valid_in(rxv), .rx_word_in(rxw),
    .rx_last_in(rxl));
  fifo_alloc_monitor fifo_alloc_monitor_i (.core_clk_in(clk),
    .rst_in(rst), .addr_in(fifo_alloc_if_i.addr),
    .rd_in(fifo_alloc_if_i.rd), .wr_in(fifo_alloc_if_i.wr),
    .wdata_in(fifo_alloc_if_i.wdata), .rdata_in(fifo_alloc_if_i.rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string s, input logic [31:0] v,
                       input logic [31:0] e);
    n_compared++;
    if (v !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 200);
    if (hrdy !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string s);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(s, q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // poll until bit b reads 0; a stuck bit ends the run
  task automatic poll(input logic [7:0] a, input int b);
    logic [31:0] q;
    for (int i = 0; i < 100; i++) begin
      bus(1'b0, a, 32'h0, q);
      if (q[b] === 1'b0) return;
    end
    n_mismatch++;
    report_and_stop();
  endtask

  task automatic software_reset_trigger();
    wr(fifo_alloc_pkg::HW_CONFIG, {12'h000, cur_sel, 16'h0001});
    poll(fifo_alloc_pkg::HW_CONFIG, 0);
  endtask

  // mac has no ready: one word every cycle
  task automatic rx_frame(input int n, input logic [31:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxv <= 1'b1;
      rxw <= base + 32'(i);
      rxl <= (i == n - 1);
    end
    @(posedge clk);
    rxv <= 1'b0;
    rxl <= 1'b0;
  endtask

  initial begin
    int tx, rx;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {phy, transmit_error_flag, receive_error_flag, txr, rxv, rxl, rxw} = '0;
    phy = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    cur_sel = 4'h5;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(fifo_alloc_pkg::HW_CONFIG, 32'h00050000, "config");
    rd(fifo_alloc_pkg::ERROR_STATUS, 32'h0, "errors");
    rd(fifo_alloc_pkg::RX_DP_CONTROL, 32'h0, "skip");
    rd(8'h7C, 32'h0, "unmapped");
    $display("test reset_values done");
    for (int s = 2; s <= 14; s++) begin
      tx = s * 1024;
      rx = 16384 - tx;
      wr(fifo_alloc_pkg::HW_CONFIG, {12'h000, 4'(s), 16'h0000});
      rd(fifo_alloc_pkg::ALLOC_DATA, {16'(rx - rx / 16), 16'(tx - 512)},
         "alloc data");
      rd(fifo_alloc_pkg::ALLOC_STATUS, {16'h0200, 16'(rx / 16)},
         "alloc status");
    end
    wr(fifo_alloc_pkg::HW_CONFIG, 32'h000F0000);
    wr(fifo_alloc_pkg::HW_CONFIG, 32'h00010000);
    rd(fifo_alloc_pkg::HW_CONFIG, 32'h000E0000, "select");
    $display("test allocation done");
    @(posedge clk);
    transmit_error_flag <= 1'b1;
    receive_error_flag <= 1'b1;
    @(posedge clk);
    transmit_error_flag <= 1'b0;
    receive_error_flag <= 1'b0;
    rd(fifo_alloc_pkg::ERROR_STATUS, 32'h3, "errors set");
    cur_sel = 4'hE;
    software_reset_trigger();
    rd(fifo_alloc_pkg::ERROR_STATUS, 32'h0, "errors cleared");
    rd(fifo_alloc_pkg::HW_CONFIG, 32'h000E0000, "kept");
    phy <= 1'b0;
    software_reset_trigger();
    rd(fifo_alloc_pkg::HW_CONFIG, 32'h000E0002, "timeout");
    phy <= 1'b1;
    software_reset_trigger();
    rd(fifo_alloc_pkg::HW_CONFIG, 32'h000E0000, "timeout clear");
    $display("test soft_reset done");
    wr(fifo_alloc_pkg::TX_DATA_PORT, 32'hA5A50001);
    wr(fifo_alloc_pkg::TX_DATA_LAST, 32'hA5A50002);
    repeat (3) @(posedge clk);
    #1;
    check("tx word", txw, 32'hA5A50001);
    check("tx flags", {30'h0, txv, txl}, 32'h2);
    @(posedge clk);
    txr <= 1'b1;
    @(posedge clk);
    txr <= 1'b0;
    #1;
    check("tx word", txw, 32'hA5A50002);
    check("tx flags", {30'h0, txv, txl}, 32'h3);
    @(posedge clk);
    txr <= 1'b1;
    @(posedge clk);
    txr <= 1'b0;
    #1;
    check("tx empty", {31'h0, txv}, 32'h0);
    $display("test transmit done");
    rx_frame(3, 32'h100);
    rx_frame(2, 32'h200);
    repeat (4) @(posedge clk);
    rd(fifo_alloc_pkg::RX_USED, 32'h14, "rx used");
    rd(fifo_alloc_pkg::RX_DATA_PORT, 32'h100, "rx word");
    wr(fifo_alloc_pkg::RX_DP_CONTROL, 32'h80000000);
    poll(fifo_alloc_pkg::RX_DP_CONTROL, 31);
    rd(fifo_alloc_pkg::RX_DATA_PORT, 32'h200, "after skip");
    rd(fifo_alloc_pkg::RX_USED, 32'h4, "rx used");
    $display("test skip done");
    software_reset_trigger();
    // 1920-byte rx data fifo: full at 476 words, then 32 staged
    rx_frame(600, 32'h1000);
    rx_frame(4, 32'h3000);
    repeat (4) @(posedge clk);
    rd(fifo_alloc_pkg::DROP_COUNT, 32'h2, "drops");
    rd(fifo_alloc_pkg::RX_USED, 32'h770, "rx full");
    software_reset_trigger();
    rd(fifo_alloc_pkg::DROP_COUNT, 32'h0, "drops cleared");
    rd(fifo_alloc_pkg::RX_USED, 32'h0, "rx cleared");
    // empty pop returns zero and latches the receive error
    rd(fifo_alloc_pkg::RX_DATA_PORT, 32'h0, "empty read");
    rd(fifo_alloc_pkg::ERROR_STATUS, 32'h2, "empty flag");
    check("response", {31'h0, hresp}, 32'h0);
    $display("test overrun done");
    report_and_stop();
  end
endmodule
